// >>> pkg/soft_trigger_defines.svh
// Constants for the software event trigger block: offsets, field positions, reset values.
// Assumes a plain register port with byte addresses on 32-bit words.
// Summary of operation
// R01: Writing 1 to a line's trigger bit makes a rising-edge event and interrupt; 0 does nothing. Here a 1 written while the bit is set is ignored.
// R02: Hardware clears a set trigger bit; reads return written value before, 0 after.
// R03: Line 9 trigger bit self-clears and always reads as 0.
// R04: One trigger bit per line 0 to 9, at the bit equal to the line number.
// R05: A software event sets the line's pending flag until software writes 1 to it.
// R06: Trigger bits reset to 0 and cause no action while 0.
`ifndef SOFT_TRIGGER_DEFINES_SVH
`define SOFT_TRIGGER_DEFINES_SVH
`define NUM_LINES          10
`define SELF_CLEAR_LINE    9
`define OFS_TRIGGER        8'h00
`define OFS_PENDING        8'h04
`define OFS_MASK           8'h08
`define TRIGGER_RESET      10'h000
`define PENDING_RESET      10'h000
`define MASK_RESET         10'h000
`define CLEAR_DELAY_CYCLES 2'h1
`endif

// >>> pkg/soft_trigger_pkg.sv
// Types shared by the software event trigger block.
// Assumes the constant header is included where sizes are needed.
package soft_trigger_pkg;
  typedef logic [9:0]  line_vec_t;
  typedef logic [7:0]  reg_addr_t;
  typedef logic [31:0] reg_data_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01
  } clear_state_t;
endpackage

// >>> rtl/irq_status.sv
// Sticky pending flags, mask and the level interrupt output.
// Assumes one clock; events are one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
`include "soft_trigger_defines.svh"
module irq_status (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // Events and software access
  input  wire soft_trigger_pkg::line_vec_t set_vec,
  input  wire soft_trigger_pkg::line_vec_t clr_vec,
  input  wire soft_trigger_pkg::line_vec_t mask_vec,
  // State
  output soft_trigger_pkg::line_vec_t      pending,
  output logic                             irq
);
  import soft_trigger_pkg::*;
  typedef struct packed {
    line_vec_t flags;
  } stat_state_t;
  stat_state_t s;
  stat_state_t next_s;

  always_comb begin
    next_s = s;
    // Set wins over a same-cycle write-one clear so no event is lost.
    next_s.flags = (s.flags & ~clr_vec) | set_vec; // [R05]
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s.flags <= `PENDING_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign pending = s.flags;
  assign irq     = |(s.flags & mask_vec);

  a_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
    |set_vec |=> ((pending & $past(set_vec)) == $past(set_vec)))
    else $error("pending flag not set"); // [R05]
  a_flag_holds: assert property (@(posedge clk) disable iff (sys_rst)
    (pending[0] && !clr_vec[0]) |=> pending[0]) else $error("flag dropped"); // [R05]
endmodule
`default_nettype wire

// >>> rtl/soft_event_trigger_lines.sv
// Software event trigger lines 0 to 9 with pending flags, mask and interrupt.
// Assumes a simple register port: one-cycle strobes, read data one cycle later.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "soft_trigger_defines.svh"
module soft_event_trigger_lines (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // Register port
  input  wire soft_trigger_pkg::reg_addr_t reg_addr,
  input  wire soft_trigger_pkg::reg_data_t reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output soft_trigger_pkg::reg_data_t      reg_rdata,
  // Per-line outputs and the interrupt
  output soft_trigger_pkg::line_vec_t      line_event,
  output soft_trigger_pkg::line_vec_t      line_pending_flag,
  output logic                             irq
);
  import soft_trigger_pkg::*;
  typedef struct packed {
    line_vec_t mask;
    reg_data_t rdata;
    line_vec_t evt;
  } top_state_t;
  top_state_t s;
  top_state_t next_s;
  line_vec_t  trig_bits;
  line_vec_t  trig_pulse;
  line_vec_t  wr_trig;
  line_vec_t  wr_clr;

  function automatic logic hit(input reg_addr_t a, input reg_addr_t ofs);
    hit = (a == ofs);
  endfunction

  assign wr_trig = (reg_wr && hit(reg_addr, `OFS_TRIGGER)) ? reg_wdata[9:0] : '0; // [R01]
  assign wr_clr  = (reg_wr && hit(reg_addr, `OFS_PENDING)) ? reg_wdata[9:0] : '0;

  genvar i;
  generate
    for (i = 0; i < `NUM_LINES; i++) begin : g_line
      trigger_line u_line (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .set_req     (wr_trig[i]), // [R04]
        .trigger_bit (trig_bits[i]),
        .event_pulse (trig_pulse[i])
      );
    end
  endgenerate

  irq_status u_stat (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .set_vec  (trig_pulse), // [R05]
    .clr_vec  (wr_clr),
    .mask_vec (s.mask),
    .pending  (line_pending_flag),
    .irq      (irq)
  );

  always_comb begin
    line_vec_t vis;
    vis = trig_bits;
    // Line 9's trigger bit has no visible state: software always reads it back as zero.
    vis[`SELF_CLEAR_LINE] = 1'b0; // [R03]
    next_s = s;
    next_s.evt = trig_pulse;
    next_s.rdata = '0;
    if (reg_wr && hit(reg_addr, `OFS_MASK)) begin
      next_s.mask = reg_wdata[9:0];
    end
    if (reg_rd) begin
      if (hit(reg_addr, `OFS_TRIGGER)) begin
        next_s.rdata = {22'h000000, vis}; // [R02]
      end else if (hit(reg_addr, `OFS_PENDING)) begin
        next_s.rdata = {22'h000000, line_pending_flag};
      end else if (hit(reg_addr, `OFS_MASK)) begin
        next_s.rdata = {22'h000000, s.mask};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s.mask  <= `MASK_RESET;
      s.rdata <= 32'h0000_0000;
      s.evt   <= 10'h000;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata  = s.rdata;
  assign line_event = s.evt;

  a_write_event: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_wr && reg_addr == 8'h00 && reg_wdata[3] && !trig_bits[3]) |=> line_event[3])
    else $error("no event after trigger write"); // [R01]
  a_zero_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    !wr_trig[5] |=> !line_event[5]) else $error("event without write"); // [R06]
  a_line9_reads0: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_addr == 8'h00) |=> !reg_rdata[9]) else $error("line 9 read nonzero"); // [R03]
  a_read_before: assert property (@(posedge clk) disable iff (sys_rst)
    (reg_rd && reg_addr == 8'h00 && trig_bits[2]) |=> reg_rdata[2])
    else $error("written value not seen"); // [R02]
  a_pend_after: assert property (@(posedge clk) disable iff (sys_rst)
    line_event[0] |-> line_pending_flag[0]) else $error("pending not set"); // [R05]
  a_rsv_zero: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rdata[31:10] == 22'h0) else $error("reserved bits set"); // [R04]
  // Every line gets the same checks, so a fault on a single line cannot hide.
  genvar j;
  generate
    for (j = 0; j < `NUM_LINES; j++) begin : g_chk
      a_line_event: assert property (@(posedge clk) disable iff (sys_rst) // [R01]
        (wr_trig[j] && !trig_bits[j]) |=> line_event[j])
        else $error("line event missing");
      a_line_quiet: assert property (@(posedge clk) disable iff (sys_rst) // [R06]
        !wr_trig[j] |=> !line_event[j]) else $error("line event unexpected");
      a_line_pend: assert property (@(posedge clk) disable iff (sys_rst) // [R05]
        line_event[j] |-> line_pending_flag[j]) else $error("line pending missing");
      a_line_clear: assert property (@(posedge clk) disable iff (sys_rst) // [R02]
        trig_bits[j] |=> !trig_bits[j]) else $error("line trigger not cleared");
    end
  endgenerate
  c_trigger: cover property (@(posedge clk) |line_event);
  c_irq: cover property (@(posedge clk) irq);
  c_clear: cover property (@(posedge clk) (reg_wr && reg_addr == 8'h04 && |line_pending_flag));
endmodule
`default_nettype wire

// >>> rtl/trigger_line.sv
// One line's trigger bit with its hardware clear sequence.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module trigger_line (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Software write of this bit
  input  wire logic set_req,
  // Bit state and its one-cycle event
  output logic      trigger_bit,
  output logic      event_pulse
);
  import soft_trigger_pkg::*;
  typedef struct packed {
    clear_state_t st;
    logic         bit_q;
  } line_state_t;
  line_state_t s;
  line_state_t next_s;

  always_comb begin
    next_s = s;
    case (s.st)
      ST_IDLE: begin
        if (set_req) begin // [R01]
          next_s.bit_q = 1'b1;
          next_s.st    = ST_ARMED;
        end
      end
      ST_ARMED: begin
        // The bit stays visible one cycle so a read can see the written value.
        next_s.bit_q = 1'b0; // [R02]
        next_s.st    = ST_IDLE;
      end
      default: next_s = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0; // [R06]
    end else begin
      s <= next_s;
    end
  end

  assign trigger_bit = s.bit_q;
  assign event_pulse = (s.st == ST_IDLE) && set_req; // [R01]

  a_bit_clears: assert property (@(posedge clk) disable iff (sys_rst)
    trigger_bit |=> !trigger_bit) else $error("trigger bit not cleared"); // [R02]
  a_set_follows: assert property (@(posedge clk) disable iff (sys_rst)
    event_pulse |=> trigger_bit) else $error("trigger bit not set"); // [R01]
endmodule
`default_nettype wire

// >>> testbench/soft_event_trigger_lines_tb.sv
// Self-checking bench for the software event trigger lines.
// Assumes the design package and the constant header are on the compile path.
`timescale 1ns/10ps
`default_nettype none
`include "soft_trigger_defines.svh"
module soft_event_trigger_lines_tb;
  import soft_trigger_pkg::*;
  logic      clk = 1'b0;
  logic      sys_rst = 1'b1;
  reg_addr_t reg_addr = 8'h00;
  reg_data_t reg_wdata = 32'h0;
  logic      reg_wr = 1'b0;
  logic      reg_rd = 1'b0;
  reg_data_t reg_rdata;
  line_vec_t line_event;
  line_vec_t line_pending_flag;
  logic      irq;
  line_vec_t pend_exp;
  line_vec_t mask_exp;
  line_vec_t bit_n;
  line_vec_t clr;
  int        n;
  int        err_total = 0;
  int        checks_done = 0;

  soft_event_trigger_lines i_dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_event(line_event),
    .line_pending_flag(line_pending_flag), .irq(irq));

  initial begin
    forever #20 clk = ~clk;
  end

  function automatic reg_data_t trig_read(input int k);
    // The self-clearing line never shows the written one.
    return (k == `SELF_CLEAR_LINE) ? 32'h0 : 32'h1 << k;
  endfunction

  function automatic logic irq_exp();
    return |(pend_exp & mask_exp);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Called right after a rising edge; returns at the edge that takes the write.
  task automatic wr(input reg_addr_t a, input reg_data_t d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input reg_addr_t a, input reg_data_t exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
    @(posedge clk);
  endtask

  task automatic stop_test();
    $display("checks_done %0d err_total %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    stop_test();
  end

  initial begin
    void'($urandom(50990));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    pend_exp = 10'h000;
    mask_exp = 10'h000;
    rd(`OFS_TRIGGER, 32'h0);
    rd(`OFS_PENDING, 32'h0);
    chk(32'(irq), 32'h0);
    $display("test reset done");
    // First pass walks every line in order, the rest pick lines at random.
    for (int k = 0; k < 20; k++) begin
      n = (k < `NUM_LINES) ? k : int'($urandom_range(9));
      bit_n = 10'h001 << n;
      mask_exp = line_vec_t'($urandom);
      wr(`OFS_MASK, 32'(mask_exp));
      @(posedge clk);
      wr(`OFS_TRIGGER, ($urandom & 32'hffff_fc00) | 32'(bit_n));
      pend_exp = pend_exp | bit_n;
      fork
        rd(`OFS_TRIGGER, trig_read(n));
        begin
          @(negedge clk);
          chk(32'(line_event), 32'(bit_n));
          chk(32'(line_pending_flag), 32'(pend_exp));
          chk(32'(irq), 32'(irq_exp()));
        end
      join
      rd(`OFS_TRIGGER, 32'h0);
      clr = line_vec_t'($urandom);
      wr(`OFS_PENDING, 32'(clr));
      pend_exp = pend_exp & ~clr;
      rd(`OFS_PENDING, 32'(pend_exp));
      rd(`OFS_MASK, 32'(mask_exp));
      chk(32'(irq), 32'(irq_exp()));
      wr(`OFS_TRIGGER, $urandom & 32'hffff_fc00);
      @(negedge clk);
      chk(32'(line_event), 32'h0);
      chk(32'(line_pending_flag), 32'(pend_exp));
      @(posedge clk);
    end
    $display("test lines done");
    wr(8'h0c, $urandom);
    rd(8'h0c, 32'h0);
    rd(`OFS_PENDING, 32'(pend_exp));
    $display("test unmapped done");
    stop_test();
  end
endmodule
`default_nettype wire
